/* verilog/aof_pkg.sv */
`default_nettype none
package aof_pkg;

    // Register offsets, kept as printed
    localparam logic [7:0] ADDR_LFNS    = 8'h14;
    localparam logic [7:0] ADDR_GAIN_LO = 8'h2A;
    localparam logic [7:0] ADDR_GAIN_HI = 8'h2B;
    localparam logic [7:0] ADDR_CLK_REF = 8'h42;
    localparam logic [7:0] ADDR_PATTERN = 8'h45;
    localparam logic [7:0] ADDR_FORMAT  = 8'h46;
    localparam logic [7:0] ADDR_STATUS  = 8'h47;

    // Field positions
    localparam int DIFF_BIT   = 0;
    localparam int DCC_BIT    = 2;
    localparam int REF_BIT    = 3;
    localparam int PHASE_LSB  = 5;
    localparam int DESKEW_BIT = 0;
    localparam int SYNC_BIT   = 1;
    localparam int BTC_BIT    = 2;
    localparam int MSB_BIT    = 3;
    localparam int SDR_BIT    = 4;
    localparam int FALL_BIT   = 13;

    // Values after reset
    localparam logic [1:0]  PHASE_RST  = 2'h0;
    localparam logic [15:0] GAIN_RST   = 16'h0000;
    localparam logic [7:0]  LFNS_RST   = 8'h00;
    localparam logic [3:0]  IDX_RST    = 4'hB;

    // Test words, frame geometry and top gain code
    localparam logic [11:0] DESKEW_WORD = 12'h555;
    localparam logic [11:0] SYNC_WORD   = 12'hFC0;
    localparam logic [3:0]  LAST_BIT    = 4'hB;
    localparam logic [3:0]  HALF_FRAME  = 4'h6;
    localparam logic [3:0]  GAIN_MAX    = 4'hC;

    typedef struct packed {
        logic       differential_clock_select;
        logic       duty_cycle_correction_enable;
        logic       reference_from_common_mode_pin;
        logic [1:0] bit_clock_phase;
    } aof_analog_cfg_t;

    typedef struct packed {
        logic twos_complement_select;
        logic msb_first;
        logic single_rate_output_enable;
        logic single_rate_edge_select;
    } aof_format_cfg_t;

    typedef enum logic [1:0] {
        SER_IDLE  = 2'b01,
        SER_SHIFT = 2'b10
    } aof_ser_state_t;

endpackage
`default_nettype wire

/* verilog/aof_config_bank.sv */
`default_nettype none

// What this block does
// R01: Register 0x42 bit 0 set selects differential clock; clear, single-ended.
// R02: Register 0x42 bit 2 enables duty-cycle correction; off after reset.
// R03: Register 0x42 bit 3 takes reference from common-mode pin; default top/bottom pins.
// R04: Register 0x42 bits 6:5 set bit-clock phase; reset code means 90 degrees.
// R05: Register 0x45 bit 0 enables deskew pattern; host keeps bit 1 clear.
// R06: Register 0x45 bit 1 enables sync pattern; host keeps bit 0 clear; both off.
// R07: Register 0x46 bit 2 selects two's complement; default offset binary.
// R08: Register 0x46 bit 3 sends MSB first; default LSB first.
// R09: Register 0x46 bit 4 selects single-rate output; default double rate.
// R10: Register 0x46 bit 13 picks SDR mid-window bit-clock edge; host sets bit 4.
// R11: Per-channel digital gain 0 to 12 dB from 0x2A/0x2B, reset 0 dB.
// R12: Noise suppression on with zero input makes output toggle at half sample rate.
// R13: Host writes ones into every bit the map forces to one.
// R14: Host writes zero into every unused bit.
// R15: Host programs all functions of one register in a single write.
// R16: Without a test pattern the serializer sends coded, ordered, rate-shaped samples.
module aof_config_bank #(
    parameter int LANE = 0
) (
    // Clock and reset
    input  wire logic                      clock_i,
    input  wire logic                      resetn_i,
    // Register port
    input  wire logic [7:0]                reg_addr_i,
    input  wire logic [15:0]               reg_wdata_i,
    input  wire logic                      reg_we_i,
    input  wire logic                      reg_re_i,
    output var  logic [15:0]               reg_rdata_o,
    // Sample input for this lane
    input  wire logic [11:0]               sample_i,
    input  wire logic                      sample_valid_i,
    // Analog configuration levels
    output var  aof_pkg::aof_analog_cfg_t  analog_cfg_o,
    // Serial output lane
    output var  logic                      serial_data_o,
    output var  logic                      output_bit_clock_o,
    output var  logic                      frame_clock_o
);

    // Register state
    aof_pkg::aof_format_cfg_t fmt_r;
    logic [1:0]               pat_r;
    logic [15:0]              gain_lo_r;
    logic [15:0]              gain_hi_r;
    logic [7:0]               lfns_r;
    logic [15:0]              rdata_nxt;

    // Serializer state
    aof_pkg::aof_ser_state_t  st_r;
    logic [11:0]              hold_r;
    logic [11:0]              word_r;
    logic [3:0]               idx_r;
    logic                     half_r;
    logic                     tog_r;
    logic                     zero_tgl_r;
    logic [3:0]               gap_r;
    logic                     frame_dirty_r;

    // Gain code to Q8 factor, codes above 12 dB clamp
    function automatic logic [9:0] gain_q8(input logic [3:0] code);
        logic [9:0] g;
        g = 10'h3FC;
        case (code)
            4'h0: g = 10'h100;
            4'h1: g = 10'h11F;
            4'h2: g = 10'h142;
            4'h3: g = 10'h16A;
            4'h4: g = 10'h196;
            4'h5: g = 10'h1C8;
            4'h6: g = 10'h1FF;
            4'h7: g = 10'h23D;
            4'h8: g = 10'h283;
            4'h9: g = 10'h2D2;
            4'hA: g = 10'h32A;
            4'hB: g = 10'h38D;
            default: g = 10'h3FC;
        endcase
        return g;
    endfunction

    // Analog configuration register
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            analog_cfg_o.differential_clock_select      <= 1'b0;
            analog_cfg_o.duty_cycle_correction_enable   <= 1'b0;
            analog_cfg_o.reference_from_common_mode_pin <= 1'b0;
            analog_cfg_o.bit_clock_phase                <= aof_pkg::PHASE_RST;
        end else if (reg_we_i && reg_addr_i == aof_pkg::ADDR_CLK_REF) begin
            // Whole register replaced by each write
            analog_cfg_o.differential_clock_select      <= reg_wdata_i[aof_pkg::DIFF_BIT];  // [R01]
            analog_cfg_o.duty_cycle_correction_enable   <= reg_wdata_i[aof_pkg::DCC_BIT];   // [R02]
            analog_cfg_o.reference_from_common_mode_pin <= reg_wdata_i[aof_pkg::REF_BIT];   // [R03]
            analog_cfg_o.bit_clock_phase <= reg_wdata_i[aof_pkg::PHASE_LSB +: 2];           // [R04]
        end
    end

    // Test pattern and output format registers
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pat_r <= 2'h0;
            fmt_r <= '0;
        end else if (reg_we_i && reg_addr_i == aof_pkg::ADDR_PATTERN) begin
            pat_r <= {reg_wdata_i[aof_pkg::SYNC_BIT], reg_wdata_i[aof_pkg::DESKEW_BIT]};  // [R05] [R06]
        end else if (reg_we_i && reg_addr_i == aof_pkg::ADDR_FORMAT) begin
            fmt_r.twos_complement_select    <= reg_wdata_i[aof_pkg::BTC_BIT];  // [R07]
            fmt_r.msb_first                 <= reg_wdata_i[aof_pkg::MSB_BIT];  // [R08]
            fmt_r.single_rate_output_enable <= reg_wdata_i[aof_pkg::SDR_BIT];  // [R09]
            fmt_r.single_rate_edge_select   <= reg_wdata_i[aof_pkg::FALL_BIT]; // [R10]
        end
    end

    // Gain and noise suppression registers
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gain_lo_r <= aof_pkg::GAIN_RST;
            gain_hi_r <= aof_pkg::GAIN_RST;
            lfns_r    <= aof_pkg::LFNS_RST;
        end else if (reg_we_i && reg_addr_i == aof_pkg::ADDR_GAIN_LO) begin
            gain_lo_r <= reg_wdata_i;  // [R11]
        end else if (reg_we_i && reg_addr_i == aof_pkg::ADDR_GAIN_HI) begin
            gain_hi_r <= reg_wdata_i;  // [R11]
        end else if (reg_we_i && reg_addr_i == aof_pkg::ADDR_LFNS) begin
            lfns_r <= reg_wdata_i[7:0];
        end
    end

    // Read decode; unmapped addresses and forced bits read zero
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_addr_i == aof_pkg::ADDR_CLK_REF) begin
            rdata_nxt[aof_pkg::DIFF_BIT]       = analog_cfg_o.differential_clock_select;
            rdata_nxt[aof_pkg::DCC_BIT]        = analog_cfg_o.duty_cycle_correction_enable;
            rdata_nxt[aof_pkg::REF_BIT]        = analog_cfg_o.reference_from_common_mode_pin;
            rdata_nxt[aof_pkg::PHASE_LSB +: 2] = analog_cfg_o.bit_clock_phase;
        end else if (reg_addr_i == aof_pkg::ADDR_PATTERN) begin
            rdata_nxt[1:0] = pat_r;
        end else if (reg_addr_i == aof_pkg::ADDR_FORMAT) begin
            rdata_nxt[aof_pkg::BTC_BIT]  = fmt_r.twos_complement_select;
            rdata_nxt[aof_pkg::MSB_BIT]  = fmt_r.msb_first;
            rdata_nxt[aof_pkg::SDR_BIT]  = fmt_r.single_rate_output_enable;
            rdata_nxt[aof_pkg::FALL_BIT] = fmt_r.single_rate_edge_select;
        end else if (reg_addr_i == aof_pkg::ADDR_GAIN_LO) begin
            rdata_nxt = gain_lo_r;
        end else if (reg_addr_i == aof_pkg::ADDR_GAIN_HI) begin
            rdata_nxt = gain_hi_r;
        end else if (reg_addr_i == aof_pkg::ADDR_LFNS) begin
            rdata_nxt[7:0] = lfns_r;
        end else if (reg_addr_i == aof_pkg::ADDR_STATUS) begin
            rdata_nxt[3:0] = {zero_tgl_r, pat_r, st_r == aof_pkg::SER_SHIFT};
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 16'h0000;
        end else begin
            reg_rdata_o <= reg_re_i ? rdata_nxt : 16'h0000;
        end
    end

    // Lane gain nibble: 0x2A holds lanes 0-3 upward, 0x2B lanes 4-7 downward
    localparam int GSH = (LANE < 4) ? 4 * LANE : 4 * (7 - LANE);
    logic [3:0]         lane_gain;
    logic               lane_lfns;
    logic signed [11:0] s_in;
    logic signed [22:0] prod;
    logic signed [14:0] scaled;
    logic signed [11:0] sat;
    logic [11:0]        coded;
    logic [11:0]        next_word;
    logic [11:0]        cur_word;
    logic [3:0]         cur_idx;
    logic [3:0]         bit_sel;
    logic               bit_en;
    logic               load;

    assign lane_gain = (LANE < 4) ? gain_lo_r[GSH +: 4] : gain_hi_r[GSH +: 4];
    assign lane_lfns = lfns_r[LANE];

    // Gain about midscale, saturating to full scale
    always_comb begin
        s_in   = $signed({~hold_r[11], hold_r[10:0]});
        prod   = s_in * $signed({1'b0, gain_q8(lane_gain)});  // [R11]
        scaled = prod[22:8];
        if (scaled > 15'sd2047) begin
            sat = 12'sh7FF;
        end else if (scaled < -15'sd2048) begin
            sat = 12'sh800;
        end else begin
            sat = scaled[11:0];
        end
        // Zero input alternates midscale and one below, flipping each frame
        if (lane_lfns && s_in == 12'sh000) begin
            sat = zero_tgl_r ? 12'shFFF : 12'sh000;  // [R12]
        end
    end

    // Coding, then test pattern override; deskew wins if host sets both
    always_comb begin
        coded = fmt_r.twos_complement_select ? sat : {~sat[11], sat[10:0]};  // [R07]
        if (pat_r[0]) begin
            next_word = aof_pkg::DESKEW_WORD;  // [R05]
        end else if (pat_r[1]) begin
            next_word = aof_pkg::SYNC_WORD;    // [R06]
        end else begin
            next_word = coded;                 // [R16]
        end
    end

    // Bit timing: SDR spends two clocks per bit, DDR one
    assign bit_en   = (st_r == aof_pkg::SER_SHIFT) && (!fmt_r.single_rate_output_enable || half_r);  // [R09]
    assign load     = bit_en && idx_r == aof_pkg::LAST_BIT;
    assign cur_word = load ? next_word : word_r;
    assign cur_idx  = load ? 4'h0 : idx_r + 4'h1;
    assign bit_sel  = fmt_r.msb_first ? aof_pkg::LAST_BIT - cur_idx : cur_idx;  // [R08]

    // Serializer state: idle until the first sample arrives
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= aof_pkg::SER_IDLE;
        end else begin
            case (st_r)
                aof_pkg::SER_IDLE:  st_r <= sample_valid_i ? aof_pkg::SER_SHIFT : aof_pkg::SER_IDLE;
                aof_pkg::SER_SHIFT: st_r <= aof_pkg::SER_SHIFT;
                default:            st_r <= aof_pkg::SER_IDLE;
            endcase
        end
    end

    // Latest sample is held until the next frame picks it up
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold_r <= 12'h000;
        end else if (sample_valid_i) begin
            hold_r <= sample_i;
        end
    end

    // Frame position, word and noise-suppression toggle
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            idx_r      <= aof_pkg::IDX_RST;
            word_r     <= 12'h000;
            zero_tgl_r <= 1'b0;
        end else if (bit_en) begin
            idx_r  <= cur_idx;
            word_r <= cur_word;
            if (load) begin
                zero_tgl_r <= ~zero_tgl_r;  // [R12]
            end
        end
    end

    // Frame length watch for the DDR check; any SDR time in a frame makes it unfit to judge
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gap_r         <= 4'h0;
            frame_dirty_r <= 1'b1;
        end else if (load) begin
            gap_r         <= 4'h0;
            frame_dirty_r <= fmt_r.single_rate_output_enable;
        end else begin
            gap_r         <= (gap_r == 4'hF) ? gap_r : gap_r + 4'h1;
            frame_dirty_r <= frame_dirty_r | fmt_r.single_rate_output_enable;
        end
    end

    // Half-bit phase, used only in SDR
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            half_r <= 1'b0;
        end else if (st_r == aof_pkg::SER_SHIFT && fmt_r.single_rate_output_enable) begin
            half_r <= ~half_r;
        end else begin
            half_r <= 1'b0;
        end
    end

    // Line outputs; bit clock edge placement depends on rate mode
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            serial_data_o      <= 1'b0;
            frame_clock_o      <= 1'b0;
            output_bit_clock_o <= 1'b0;
            tog_r              <= 1'b0;
        end else if (st_r == aof_pkg::SER_SHIFT) begin
            if (bit_en) begin
                serial_data_o <= cur_word[bit_sel];  // [R16]
                frame_clock_o <= cur_idx < aof_pkg::HALF_FRAME;
                tog_r         <= ~tog_r;
            end
            if (fmt_r.single_rate_output_enable) begin
                // Rising edge mid window unless falling is selected
                output_bit_clock_o <= ~half_r ^ fmt_r.single_rate_edge_select;  // [R10]
            end else begin
                // DDR toggles per bit; upper phase bit inverts, clock granularity limits the rest
                output_bit_clock_o <= ~tog_r ^ analog_cfg_o.bit_clock_phase[1];  // [R04]
            end
        end
    end

    // Checks
    a_diff_clock_write: assert property (@(posedge clock_i) disable iff (!resetn_i)  // [R01]
        reg_we_i && reg_addr_i == aof_pkg::ADDR_CLK_REF
        |=> analog_cfg_o.differential_clock_select == $past(reg_wdata_i[0]))
        else $error("differential clock select not taken from write");

    a_dcc_ref_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)  // [R02]
        !(reg_we_i && reg_addr_i == aof_pkg::ADDR_CLK_REF)
        |=> $stable(analog_cfg_o.duty_cycle_correction_enable)
            && $stable(analog_cfg_o.reference_from_common_mode_pin))
        else $error("analog config changed without a write");

    a_ref_pin_write: assert property (@(posedge clock_i) disable iff (!resetn_i)  // [R03]
        reg_we_i && reg_addr_i == aof_pkg::ADDR_CLK_REF
        |=> analog_cfg_o.reference_from_common_mode_pin == $past(reg_wdata_i[3])
            && analog_cfg_o.bit_clock_phase == $past(reg_wdata_i[6:5]))
        else $error("reference or phase field not taken from write");

    a_deskew_word_load: assert property (@(posedge clock_i) disable iff (!resetn_i)  // [R05]
        load && pat_r[0] |=> word_r == 12'h555)
        else $error("deskew word not loaded");

    a_sync_word_load: assert property (@(posedge clock_i) disable iff (!resetn_i)  // [R06]
        load && pat_r == 2'b10 |=> word_r == 12'hFC0)
        else $error("sync word not loaded");

    a_twos_coding: assert property (@(posedge clock_i) disable iff (!resetn_i)  // [R07]
        load && pat_r == 2'b00 && !fmt_r.twos_complement_select
        |=> word_r[11] == ~$past(sat[11]))
        else $error("offset binary coding wrong");

    a_msb_first_out: assert property (@(posedge clock_i) disable iff (!resetn_i)  // [R08]
        load && fmt_r.msb_first |=> serial_data_o == word_r[11])
        else $error("first bit is not the MSB");

    a_sdr_bit_period: assert property (@(posedge clock_i) disable iff (!resetn_i)  // [R09]
        bit_en && fmt_r.single_rate_output_enable && $stable(fmt_r)
            && !(reg_we_i && reg_addr_i == aof_pkg::ADDR_FORMAT)
        |=> !bit_en ##1 bit_en)
        else $error("SDR bit period is not two clocks");

    a_ddr_frame_len: assert property (@(posedge clock_i) disable iff (!resetn_i)  // [R16]
        load && !frame_dirty_r && !fmt_r.single_rate_output_enable
        |-> gap_r == aof_pkg::LAST_BIT)
        else $error("DDR frame is not twelve bits");

    a_sdr_edge_mid: assert property (@(posedge clock_i) disable iff (!resetn_i)  // [R10]
        st_r == aof_pkg::SER_SHIFT && fmt_r.single_rate_output_enable && $stable(fmt_r)
        |=> output_bit_clock_o == ($past(half_r) ^ ~$past(fmt_r.single_rate_edge_select)))
        else $error("SDR bit clock edge misplaced");

    a_read_unmapped: assert property (@(posedge clock_i) disable iff (!resetn_i)
        reg_re_i && reg_addr_i == 8'h00 |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");

endmodule
`default_nettype wire

/* verif/aof_host_model.sv */
`default_nettype none
// Host on the register port: every word is shaped to the map before it leaves
module aof_host_model (
    // Clock
    input  wire logic        clock_i,
    // Register port, host side
    output var  logic [7:0]  reg_addr_o,
    output var  logic [15:0] reg_wdata_o,
    output var  logic        reg_we_o,
    output var  logic        reg_re_o,
    input  wire logic [15:0] reg_rdata_i
);
    timeunit 1ns;
    timeprecision 1ns;

    // Quiet port at time zero
    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 16'h0000;
        reg_we_o    = 1'b0;
        reg_re_o    = 1'b0;
    end

    // Forced ones set, unused bits cleared in 0x42/0x45/0x46 (0x14 passes as given), never both test patterns at once
    function automatic logic [15:0] shape(input logic [7:0] a, input logic [15:0] v);
        case (a)
            aof_pkg::ADDR_CLK_REF: return (v & 16'h006D) | 16'h8000;
            aof_pkg::ADDR_PATTERN: return v[0] ? (v & 16'h0001) : (v & 16'h0002);
            aof_pkg::ADDR_FORMAT:  return (v & 16'h201C) | 16'h8200 | {11'h000, v[13], 4'h0};
            default:               return v;
        endcase
    endfunction

    // Whole register in one strobe, since a later write replaces it all
    task automatic write_reg(input logic [7:0] a, input logic [15:0] v);
        @(posedge clock_i);
        reg_addr_o  <= a;
        reg_wdata_o <= shape(a, v);
        reg_we_o    <= 1'b1;
        @(posedge clock_i);
        reg_we_o    <= 1'b0;
        reg_addr_o  <= ~a;           // Released lines must not look valid
        reg_wdata_o <= ~shape(a, v);
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock_i);
        reg_addr_o <= a;
        reg_re_o   <= 1'b1;
        @(posedge clock_i);
        reg_re_o   <= 1'b0;
        reg_addr_o <= ~a;
        @(posedge clock_i);
        d = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

/* verif/aof_config_bank_test.sv */
`default_nettype none
module aof_config_bank_test;
    timeunit 1ns;
    timeprecision 1ns;

    // Stimulus and observed signals
    logic                     clock_i        = 1'b0;
    logic                     resetn_i       = 1'b0;
    logic [11:0]              sample_i       = 12'h123;
    logic                     sample_valid_i = 1'b0;
    logic [7:0]               reg_addr;
    logic [15:0]              reg_wdata;
    logic [15:0]              reg_rdata;
    logic                     reg_we;
    logic                     reg_re;
    aof_pkg::aof_analog_cfg_t analog_cfg;
    logic                     serial_data;
    logic                     bit_clock;
    logic                     frame_clock;
    int                       err_total      = 0;
    int                       n_compared     = 0;

    // 25 MHz clock
    always #20 clock_i = ~clock_i;

    aof_host_model host (.clock_i(clock_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
        .reg_we_o(reg_we), .reg_re_o(reg_re), .reg_rdata_i(reg_rdata));

    aof_config_bank #(.LANE(0)) DUT (.clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re), .reg_rdata_o(reg_rdata),
        .sample_i(sample_i), .sample_valid_i(sample_valid_i), .analog_cfg_o(analog_cfg),
        .serial_data_o(serial_data), .output_bit_clock_o(bit_clock), .frame_clock_o(frame_clock));

    // Comparisons, one per kind of result
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cfg(input aof_pkg::aof_analog_cfg_t got, input aof_pkg::aof_analog_cfg_t exp);
        chk_reg({11'h000, got}, {11'h000, exp});
    endtask

    task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
        chk_reg({4'h0, got}, {4'h0, exp});
    endtask

    task automatic tally_and_finish();
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hold register takes the sample at once; the next frame start picks it up
    task automatic load_sample(input logic [11:0] v);
        @(posedge clock_i);
        sample_i       <= v;
        sample_valid_i <= 1'b1;
        @(posedge clock_i);
        sample_valid_i <= 1'b0;
    endtask

    // Skip to a fresh frame start, then take two whole frames back to back
    task automatic grab(input int per, output logic [23:0] w, output logic [11:0] fc, output logic bc);
        int g;
        g  = 0;
        fc = 12'h000;
        @(posedge clock_i);
        while (frame_clock !== 1'b0 && g < 99) begin
            @(posedge clock_i);
            g++;
        end
        while (frame_clock !== 1'b1 && g < 99) begin
            @(posedge clock_i);
            g++;
        end
        chk_word({11'h000, frame_clock}, 12'h001);
        bc = bit_clock;
        for (int i = 0; i < 24; i++) begin
            w[i] = serial_data;
            if (i < 12) fc = fc + {11'h000, frame_clock};
            repeat (per) @(posedge clock_i);
        end
    endtask

    task automatic test_defaults();
        logic [15:0] d;
        chk_cfg(analog_cfg, {3'b000, aof_pkg::PHASE_RST});
        host.read_reg(aof_pkg::ADDR_CLK_REF, d);
        chk_reg(d, 16'h0000);
        host.read_reg(aof_pkg::ADDR_PATTERN, d);
        chk_reg(d, 16'h0000);
        host.read_reg(aof_pkg::ADDR_FORMAT, d);
        chk_reg(d, 16'h0000);
        host.read_reg(aof_pkg::ADDR_GAIN_LO, d);
        chk_reg(d, aof_pkg::GAIN_RST);
    endtask

    // Each write replaces the whole register, so earlier bits must drop
    task automatic test_clock_ref();
        logic [15:0] v [7] = '{16'h0001, 16'h0004, 16'h0008, 16'h0020, 16'h0040, 16'h0060, 16'h0000};
        logic [15:0] d;
        foreach (v[k]) begin
            host.write_reg(aof_pkg::ADDR_CLK_REF, v[k]);
            @(posedge clock_i);
            chk_cfg(analog_cfg, {v[k][0], v[k][2], v[k][3], v[k][6:5]});
            host.read_reg(aof_pkg::ADDR_CLK_REF, d);
            chk_reg(d, v[k]);
        end
    endtask

    // A hole in the map takes nothing and reads zero
    task automatic test_unmapped();
        logic [15:0] d;
        host.write_reg(8'h50, 16'hFFFF);
        host.read_reg(8'h50, d);
        chk_reg(d, 16'h0000);
        host.read_reg(8'h00, d);
        chk_reg(d, 16'h0000);
        chk_cfg(analog_cfg, 5'h00);
    endtask

    // Coding, bit order and data rate on a converted sample
    task automatic test_formats();
        logic [15:0] f [4] = '{16'h0000, 16'h0008, 16'h0004, 16'h0010};
        logic [11:0] e [4] = '{12'h123, 12'hC48, 12'h923, 12'h123};
        logic [23:0] w;
        logic [11:0] fc;
        logic        bc;
        load_sample(12'h123);
        foreach (f[k]) begin
            host.write_reg(aof_pkg::ADDR_FORMAT, f[k]);
            grab(f[k][4] ? 2 : 1, w, fc, bc);
            chk_word(w[11:0], e[k]);
            chk_word(w[23:12], e[k]);
            chk_word(fc, 12'h006);
        end
    endtask

    // Test words replace the sample, and go away when cleared
    task automatic test_patterns();
        logic [23:0] w;
        logic [11:0] fc;
        logic        bc;
        host.write_reg(aof_pkg::ADDR_FORMAT, 16'h0000);
        host.write_reg(aof_pkg::ADDR_PATTERN, 16'h0001);
        grab(1, w, fc, bc);
        chk_word(w[11:0], aof_pkg::DESKEW_WORD);
        host.write_reg(aof_pkg::ADDR_PATTERN, 16'h0002);
        grab(1, w, fc, bc);
        chk_word(w[11:0], aof_pkg::SYNC_WORD);
        host.write_reg(aof_pkg::ADDR_PATTERN, 16'h0000);
        grab(1, w, fc, bc);
        chk_word(w[11:0], 12'h123);
        // Full gain drives a low sample past the bottom rail, so it must clamp
        host.write_reg(aof_pkg::ADDR_GAIN_LO, 16'h000C);
        grab(1, w, fc, bc);
        chk_word(w[11:0], 12'h000);
    endtask

    // Bit clock level in the first half of a single-rate bit
    task automatic test_sdr_edge();
        logic [23:0] w;
        logic [11:0] fc;
        logic        bc;
        logic [15:0] d;
        host.write_reg(aof_pkg::ADDR_FORMAT, 16'h0010);
        grab(2, w, fc, bc);
        chk_word({11'h000, bc}, 12'h000);
        host.write_reg(aof_pkg::ADDR_FORMAT, 16'h2010);
        grab(2, w, fc, bc);
        chk_word({11'h000, bc}, 12'h001);
        host.read_reg(aof_pkg::ADDR_FORMAT, d);
        chk_reg(d, 16'h2010);
    endtask

    // Midscale input with suppression on flips every frame
    task automatic test_noise();
        logic [23:0] w;
        logic [11:0] fc;
        logic        bc;
        host.write_reg(aof_pkg::ADDR_FORMAT, 16'h0000);
        host.write_reg(aof_pkg::ADDR_LFNS, 16'h0001);
        load_sample(12'h800);
        grab(1, w, fc, bc);
        chk_word(w[11:0] ^ w[23:12], 12'hFFF);
        chk_word(w[11:0] & w[23:12], 12'h000);
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clock_i);
        chk_word({9'h000, serial_data, bit_clock, frame_clock}, 12'h000);
        @(posedge clock_i);
        resetn_i <= 1'b1;
        test_defaults();
        test_clock_ref();
        test_unmapped();
        test_formats();
        test_patterns();
        test_sdr_edge();
        test_noise();
        tally_and_finish();
    end

    // Watchdog, well beyond the few hundred cycles the run needs
    initial begin
        #400000;
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
